/* File: hdl/eec_defines.svh */
// Register offsets, field positions, reset values and timing counts of the error counters.
`ifndef EEC_DEFINES_SVH
`define EEC_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define EEC_ADDR_VIOLATION_HIGH 8'h00
`define EEC_ADDR_VIOLATION_LOW 8'h01
`define EEC_ADDR_CRC_ALIGN_HIGH 8'h02
`define EEC_ADDR_CRC_LOW 8'h03
`define EEC_ADDR_FAR_END_ALIGN 8'h04
`define EEC_ADDR_FAR_END_LOW 8'h05
`define EEC_ADDR_INTERRUPT_MASK_TWO 8'h17
`define EEC_ADDR_STATUS 8'h20
`define EEC_ADDR_CONTROL 8'h21

// ****************************************************************
// Field positions
// ****************************************************************
`define EEC_CTRL_FAST_INTERVAL_BIT 2
`define EEC_CTRL_VIOLATION_TYPE_BIT 1
`define EEC_CTRL_HDB3_ENABLE_BIT 0
`define EEC_FLAG_INTERVAL_TIMER_BIT 4

// ****************************************************************
// Counter widths and reset values
// ****************************************************************
`define EEC_VIOLATION_WIDTH 16
`define EEC_CRC_WIDTH 10
`define EEC_FAR_END_WIDTH 10
`define EEC_ALIGN_WIDTH 12
`define EEC_MASK_RESET 8'h00
`define EEC_CONTROL_RESET 3'h0

// ****************************************************************
// Interval timing, counted in receive line clocks
// ****************************************************************
`define EEC_LINE_RATE_HZ 64'd2048000
`define EEC_SLOW_INTERVAL_US 64'd1000000
`define EEC_FAST_INTERVAL_US 64'd62500
`define EEC_US_PER_S 64'd1000000
`define EEC_SLOW_TICKS ((`EEC_LINE_RATE_HZ * `EEC_SLOW_INTERVAL_US) / `EEC_US_PER_S)
`define EEC_FAST_TICKS ((`EEC_LINE_RATE_HZ * `EEC_FAST_INTERVAL_US) / `EEC_US_PER_S)

`endif

/* File: hdl/eec_pkg.sv */
// Types shared by the error counter block.
package eec_pkg;

   // Decoded symbol of one received line bit.
   typedef enum logic [2:0] {
      EEC_SYM_ZERO = 3'h1,
      EEC_SYM_POS = 3'h2,
      EEC_SYM_NEG = 3'h4
   } eec_symbol_t;

endpackage

/* File: hdl/eec_error_counter.sv */
// Saturating interval error counter with a held copy of the last interval.
`timescale 1ns/1ps
`default_nettype none

module eec_error_counter
   import eec_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Event input.
   input wire logic count_event,
   input wire logic count_enable,
   // Interval boundary.
   input wire logic capture,
   // Total of the previous interval.
   output logic [WIDTH-1:0] held
);

   logic [WIDTH-1:0] running;
   logic hit;
   logic full;

   assign hit = count_event & count_enable;
   assign full = &running;

   // An event in the boundary cycle opens the new interval, so none is lost.
   always_ff @(posedge clk) begin
      if (rst) begin
         running <= '0;
      end else if (capture) begin
         running <= hit ? WIDTH'(1) : '0;
      end else if (hit && !full) begin
         running <= running + WIDTH'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         held <= '0;
      end else if (capture) begin
         held <= running;
      end
   end

endmodule // eec_error_counter

`default_nettype wire

/* File: hdl/eec_top.sv */
// Error counters, interval timer and second interrupt mask of one E1 framer.
//
// Summary of operation
// - Eight mask bits; one enables, zero masks.
// - Update all counts at each interval boundary.
// - Registers hold previous interval; read in time.
// - Counters saturate at maximum, never wrap.
// - Violation count 16 bits at 0x00/0x01.
// - Type zero counts bipolar violations.
// - HDB3 substitution words are not violations.
// - Type one counts same-polarity violation pairs.
// - Violations count always, saturate at 65535.
// - CRC count 10 bits at 0x02/0x03.
// - CRC and E-bit stop on FAS/CRC loss.
// - E-bit counter counts received zero E-bits.
// - E-bit count 10 bits at 0x04/0x05.
// - Alignment count 12 bits, bits 7..2.
// - Alignment count halts on loss or search.
// - Timer flag each second or 62.5 ms.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "eec_defines.svh"

module eec_top
   import eec_pkg::*;
#(
   parameter int SLOW_TICKS = int'(`EEC_SLOW_TICKS),
   parameter int FAST_TICKS = int'(`EEC_FAST_TICKS)
) (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RST,
   // Receive line pins.
   input wire logic RX_CLK,
   input wire logic RX_POS,
   input wire logic RX_NEG,
   // Framer error events and sync state.
   input wire logic CRC_WORD_ERROR,
   input wire logic E_BIT_STROBE,
   input wire logic E_BIT_VALUE,
   input wire logic ALIGN_WORD_ERROR,
   input wire logic RECEIVE_SYNC_LOSS,
   input wire logic FAS_SYNC_LOST,
   input wire logic CRC_MF_SYNC_LOST,
   input wire logic FAS_SEARCH,
   input wire logic MF_SEARCH,
   // Status flags gated by the mask.
   input wire logic RX_CAS_MULTIFRAME_FLAG,
   input wire logic RX_ALIGN_FRAME_FLAG,
   input wire logic TX_MULTIFRAME_FLAG,
   input wire logic TX_ALIGN_FRAME_FLAG,
   input wire logic TX_CLOCK_LOSS_FLAG,
   input wire logic RX_CRC_MULTIFRAME_FLAG,
   input wire logic TX_SLIP_FLAG,
   // Register port.
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Interrupt.
   output logic IRQ
);

   localparam int TW = $clog2(SLOW_TICKS + 1);

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0] interrupt_mask_two;
   logic fast_interval_select;
   logic violation_type_select;
   logic receive_hdb3_enable;
   logic interval_timer_flag;
   logic status_read;
   logic [7:0] flags;

   // ****************************************************************
   // Receive line synchroniser
   // ****************************************************************
   logic rx_clk_meta;
   logic rx_clk_sync;
   logic rx_clk_last;
   logic rx_pos_meta;
   logic rx_pos_sync;
   logic rx_neg_meta;
   logic rx_neg_sync;
   logic bit_tick;

   // The first stage feeds only the second; the edge detect looks at later stages.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rx_clk_meta <= 1'b0;
         rx_clk_sync <= 1'b0;
         rx_clk_last <= 1'b0;
         rx_pos_meta <= 1'b0;
         rx_pos_sync <= 1'b0;
         rx_neg_meta <= 1'b0;
         rx_neg_sync <= 1'b0;
      end else begin
         rx_clk_meta <= RX_CLK;
         rx_clk_sync <= rx_clk_meta;
         rx_clk_last <= rx_clk_sync;
         rx_pos_meta <= RX_POS;
         rx_pos_sync <= rx_pos_meta;
         rx_neg_meta <= RX_NEG;
         rx_neg_sync <= rx_neg_meta;
      end
   end

   assign bit_tick = rx_clk_sync & ~rx_clk_last;

   // ****************************************************************
   // Violation detection
   // ****************************************************************
   eec_symbol_t symbol;
   logic have_mark;
   logic last_mark_pos;
   logic have_bpv;
   logic last_bpv_pos;
   logic zero_one;
   logic zero_two;
   logic is_mark;
   logic is_pos;
   logic bpv;
   logic hdb3_word;
   logic cv;
   logic violation_event;

   always_comb begin
      if (rx_pos_sync && !rx_neg_sync) begin
         symbol = EEC_SYM_POS;
      end else if (rx_neg_sync && !rx_pos_sync) begin
         symbol = EEC_SYM_NEG;
      end else begin
         symbol = EEC_SYM_ZERO;
      end
   end

   always_comb begin
      is_mark = 1'b0;
      is_pos = 1'b0;
      case (symbol)
         EEC_SYM_POS: begin
            is_mark = 1'b1;
            is_pos = 1'b1;
         end
         EEC_SYM_NEG: begin
            is_mark = 1'b1;
         end
         default: begin
            is_mark = 1'b0;
         end
      endcase
   end

   always_comb begin
      bpv = is_mark && have_mark && (is_pos == last_mark_pos);
      // A violation after two zeros closes a 000V or B00V substitution.
      hdb3_word = bpv && zero_one && zero_two;
      cv = bpv && have_bpv && (is_pos == last_bpv_pos);
      if (violation_type_select) begin
         violation_event = bit_tick && cv;
      end else begin
         violation_event = bit_tick && bpv && !(receive_hdb3_enable && hdb3_word);
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         have_mark <= 1'b0;
         last_mark_pos <= 1'b0;
         have_bpv <= 1'b0;
         last_bpv_pos <= 1'b0;
         zero_one <= 1'b0;
         zero_two <= 1'b0;
      end else if (bit_tick) begin
         if (is_mark) begin
            have_mark <= 1'b1;
            last_mark_pos <= is_pos;
         end
         if (bpv) begin
            have_bpv <= 1'b1;
            last_bpv_pos <= is_pos;
         end
         zero_one <= !is_mark;
         zero_two <= zero_one;
      end
   end

   // ****************************************************************
   // Interval timer
   // ****************************************************************
   logic [TW-1:0] tick_count;
   logic [TW-1:0] tick_limit;
   logic boundary;

   assign tick_limit = fast_interval_select ? TW'(FAST_TICKS - 1) : TW'(SLOW_TICKS - 1);

   // The compare uses >= so that a switch to the fast interval never overruns.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         tick_count <= '0;
         boundary <= 1'b0;
      end else if (bit_tick) begin
         if (tick_count >= tick_limit) begin
            tick_count <= '0;
            boundary <= 1'b1;
         end else begin
            tick_count <= tick_count + TW'(1);
            boundary <= 1'b0;
         end
      end else begin
         boundary <= 1'b0;
      end
   end

   // Set wins over the clear caused by a status read in the same cycle.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         interval_timer_flag <= 1'b0;
      end else if (boundary) begin
         interval_timer_flag <= 1'b1;
      end else if (status_read) begin
         interval_timer_flag <= 1'b0;
      end
   end

   // ****************************************************************
   // Error counters
   // ****************************************************************
   logic [`EEC_VIOLATION_WIDTH-1:0] violation_count;
   logic [`EEC_CRC_WIDTH-1:0] crc_count;
   logic [`EEC_FAR_END_WIDTH-1:0] far_end_count;
   logic [`EEC_ALIGN_WIDTH-1:0] align_count;
   logic crc_enable;
   logic align_enable;
   logic far_end_event;

   assign crc_enable = !FAS_SYNC_LOST && !CRC_MF_SYNC_LOST;
   assign align_enable = !RECEIVE_SYNC_LOSS && !FAS_SEARCH && !MF_SEARCH;
   assign far_end_event = E_BIT_STROBE && !E_BIT_VALUE;

   eec_error_counter #(
      .WIDTH(`EEC_VIOLATION_WIDTH)
   ) u_violation (
      .clk(MCLK),
      .rst(RST),
      .count_event(violation_event),
      .count_enable(1'b1),
      .capture(boundary),
      .held(violation_count)
   );

   eec_error_counter #(
      .WIDTH(`EEC_CRC_WIDTH)
   ) u_crc (
      .clk(MCLK),
      .rst(RST),
      .count_event(CRC_WORD_ERROR),
      .count_enable(crc_enable),
      .capture(boundary),
      .held(crc_count)
   );

   eec_error_counter #(
      .WIDTH(`EEC_FAR_END_WIDTH)
   ) u_far_end (
      .clk(MCLK),
      .rst(RST),
      .count_event(far_end_event),
      .count_enable(crc_enable),
      .capture(boundary),
      .held(far_end_count)
   );

   eec_error_counter #(
      .WIDTH(`EEC_ALIGN_WIDTH)
   ) u_align (
      .clk(MCLK),
      .rst(RST),
      .count_event(ALIGN_WORD_ERROR),
      .count_enable(align_enable),
      .capture(boundary),
      .held(align_count)
   );

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_ff @(posedge MCLK) begin
      if (RST) begin
         interrupt_mask_two <= `EEC_MASK_RESET;
      end else if (WR && ADDR == `EEC_ADDR_INTERRUPT_MASK_TWO) begin
         interrupt_mask_two <= WDATA;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         {fast_interval_select, violation_type_select, receive_hdb3_enable} <= `EEC_CONTROL_RESET;
      end else if (WR && ADDR == `EEC_ADDR_CONTROL) begin
         fast_interval_select <= WDATA[`EEC_CTRL_FAST_INTERVAL_BIT];
         violation_type_select <= WDATA[`EEC_CTRL_VIOLATION_TYPE_BIT];
         receive_hdb3_enable <= WDATA[`EEC_CTRL_HDB3_ENABLE_BIT];
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   logic [7:0] next_rdata;

   assign status_read = RD && ADDR == `EEC_ADDR_STATUS;

   always_comb begin
      next_rdata = 8'h00;
      case (ADDR)
         `EEC_ADDR_VIOLATION_HIGH: begin
            next_rdata = violation_count[15:8];
         end
         `EEC_ADDR_VIOLATION_LOW: begin
            next_rdata = violation_count[7:0];
         end
         `EEC_ADDR_CRC_ALIGN_HIGH: begin
            next_rdata = {align_count[11:6], crc_count[9:8]};
         end
         `EEC_ADDR_CRC_LOW: begin
            next_rdata = crc_count[7:0];
         end
         `EEC_ADDR_FAR_END_ALIGN: begin
            next_rdata = {align_count[5:0], far_end_count[9:8]};
         end
         `EEC_ADDR_FAR_END_LOW: begin
            next_rdata = far_end_count[7:0];
         end
         `EEC_ADDR_INTERRUPT_MASK_TWO: begin
            next_rdata = interrupt_mask_two;
         end
         `EEC_ADDR_STATUS: begin
            next_rdata = flags;
         end
         `EEC_ADDR_CONTROL: begin
            next_rdata = 8'h00;
            next_rdata[`EEC_CTRL_FAST_INTERVAL_BIT] = fast_interval_select;
            next_rdata[`EEC_CTRL_VIOLATION_TYPE_BIT] = violation_type_select;
            next_rdata[`EEC_CTRL_HDB3_ENABLE_BIT] = receive_hdb3_enable;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         RDATA <= next_rdata;
      end else begin
         RDATA <= 8'h00;
      end
   end

   // ****************************************************************
   // Interrupt
   // ****************************************************************
   always_comb begin
      flags = {RX_CAS_MULTIFRAME_FLAG, RX_ALIGN_FRAME_FLAG, TX_MULTIFRAME_FLAG,
               1'b0, TX_ALIGN_FRAME_FLAG, TX_CLOCK_LOSS_FLAG,
               RX_CRC_MULTIFRAME_FLAG, TX_SLIP_FLAG};
      flags[`EEC_FLAG_INTERVAL_TIMER_BIT] = interval_timer_flag;
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(flags & interrupt_mask_two);
      end
   end

endmodule // eec_top

`default_nettype wire

/* File: test/eec_line_model.sv */
// Receive line model: free-running line clock and queued bipolar symbols.
`timescale 1ns/1ps
`default_nettype none

module eec_line_model (
   // Clock.
   input wire logic clk,
   // Line pins.
   output logic rx_clk,
   output logic rx_pos,
   output logic rx_neg
);
   logic [2:0] phase = 3'h0;
   logic [1:0] q[$];

   task automatic push(input logic [1:0] s);
      q.push_back(s);
   endtask

   initial begin
      rx_clk = 1'b0;
      {rx_pos, rx_neg} = 2'h0;
   end

   // Symbols change on the falling line clock, far from the sampling rise.
   // The line rests on zeros when nothing is queued, as a real idle line would.
   always @(posedge clk) begin
      phase <= phase + 3'h1;
      rx_clk <= ~phase[2];
      if (phase == 3'h4) begin
         {rx_pos, rx_neg} <= (q.size() > 0) ? q.pop_front() : 2'h0;
      end
   end
endmodule // eec_line_model

`default_nettype wire

/* File: test/eec_top_chk.sv */
// Assertions on the register port and interrupt output of the error counters.
`timescale 1ns/1ps
`default_nettype none

module eec_top_chk (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RST,
   // Status flags.
   input wire logic RX_CAS_MULTIFRAME_FLAG,
   input wire logic RX_ALIGN_FRAME_FLAG,
   input wire logic TX_MULTIFRAME_FLAG,
   input wire logic TX_ALIGN_FRAME_FLAG,
   input wire logic TX_CLOCK_LOSS_FLAG,
   input wire logic RX_CRC_MULTIFRAME_FLAG,
   input wire logic TX_SLIP_FLAG,
   // Register port and interrupt.
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic IRQ
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   logic [7:0] mask_sh;
   logic [2:0] ctrl_sh;
   logic [7:0] flags;
   logic masked;
   logic cause;
   logic rd_stat;
   logic unmapped;

   assign flags = {RX_CAS_MULTIFRAME_FLAG, RX_ALIGN_FRAME_FLAG, TX_MULTIFRAME_FLAG, 1'b0,
      TX_ALIGN_FRAME_FLAG, TX_CLOCK_LOSS_FLAG, RX_CRC_MULTIFRAME_FLAG, TX_SLIP_FLAG};
   assign masked = |(flags & mask_sh);
   assign cause = masked | mask_sh[4];
   assign rd_stat = RD && (ADDR == 8'h20);
   assign unmapped = (ADDR > 8'h21) || ((ADDR > 8'h05) && (ADDR < 8'h17));

   // Shadow copies of the writable registers, so read-back can be judged.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         mask_sh <= 8'h00;
      end else if (WR && (ADDR == 8'h17)) begin
         mask_sh <= WDATA;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctrl_sh <= 3'h0;
      end else if (WR && (ADDR == 8'h21)) begin
         ctrl_sh <= WDATA[2:0];
      end
   end

   a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("Read data outside the read slot.");
   a_mask_readback: assert property (RD && ADDR == 8'h17 |=> RDATA == $past(mask_sh))
      else $error("Mask read-back differs from last write.");
   a_ctrl_readback: assert property (RD && ADDR == 8'h21 |=> RDATA[2:0] == $past(ctrl_sh))
      else $error("Control read-back differs from last write.");
   a_unmapped_zero: assert property (RD && unmapped |=> RDATA == 8'h00)
      else $error("Unmapped read returned data.");
   a_irq_mask: assert property (!mask_sh[4] |=> IRQ == $past(masked))
      else $error("Interrupt does not follow enabled flags.");
   a_irq_cause: assert property ($rose(IRQ) |-> $past(cause))
      else $error("Interrupt rose without an enabled cause.");
   a_masked_quiet: assert property (mask_sh == 8'h00 |=> !IRQ)
      else $error("Interrupt raised with all sources masked.");
   a_flag_sticky: assert property (IRQ && mask_sh == 8'h10 && $past(mask_sh) == 8'h10 &&
      !$past(rd_stat) |=> IRQ)
      else $error("Timer interrupt dropped before status read.");

   c_timer_irq: cover property ($rose(IRQ) && mask_sh == 8'h10);
   c_count_read: cover property (RD && ADDR == 8'h00 ##1 RDATA != 8'h00);
   c_mask_write: cover property (WR && ADDR == 8'h17);
endmodule // eec_top_chk

bind eec_top eec_top_chk eec_top_chk_inst (.MCLK(MCLK), .RST(RST),
   .RX_CAS_MULTIFRAME_FLAG(RX_CAS_MULTIFRAME_FLAG), .RX_ALIGN_FRAME_FLAG(RX_ALIGN_FRAME_FLAG),
   .TX_MULTIFRAME_FLAG(TX_MULTIFRAME_FLAG), .TX_ALIGN_FRAME_FLAG(TX_ALIGN_FRAME_FLAG),
   .TX_CLOCK_LOSS_FLAG(TX_CLOCK_LOSS_FLAG), .RX_CRC_MULTIFRAME_FLAG(RX_CRC_MULTIFRAME_FLAG),
   .TX_SLIP_FLAG(TX_SLIP_FLAG), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .IRQ(IRQ));

`default_nettype wire

/* File: test/tb_eec_top.sv */
// Self-checking bench for the error counter block.
`timescale 1ns/1ps
`default_nettype none

module tb_eec_top;
   localparam int SLOW = 200;
   localparam int FAST = 8;
   localparam int RXP = 8;
   localparam logic [1:0] P = 2'h2;
   localparam logic [1:0] N = 2'h1;
   localparam logic [1:0] Z = 2'h0;

   logic mclk, rst, wr_s, rd_s, irq, rx_clk, rx_pos, rx_neg;
   logic crc, ebs, ebv, aln;
   logic [4:0] ls;
   logic [7:0] fv, addr, wdata, rdata, d;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int tdet, t0;

   eec_line_model eec_line_model_inst (.clk(mclk), .rx_clk(rx_clk), .rx_pos(rx_pos),
      .rx_neg(rx_neg));

   eec_top #(.SLOW_TICKS(SLOW), .FAST_TICKS(FAST)) eec_top_inst (.MCLK(mclk), .RST(rst),
      .RX_CLK(rx_clk), .RX_POS(rx_pos), .RX_NEG(rx_neg), .CRC_WORD_ERROR(crc),
      .E_BIT_STROBE(ebs), .E_BIT_VALUE(ebv), .ALIGN_WORD_ERROR(aln),
      .RECEIVE_SYNC_LOSS(ls[4]), .FAS_SYNC_LOST(ls[3]), .CRC_MF_SYNC_LOST(ls[2]),
      .FAS_SEARCH(ls[1]), .MF_SEARCH(ls[0]), .RX_CAS_MULTIFRAME_FLAG(fv[7]),
      .RX_ALIGN_FRAME_FLAG(fv[6]), .TX_MULTIFRAME_FLAG(fv[5]), .TX_ALIGN_FRAME_FLAG(fv[3]),
      .TX_CLOCK_LOSS_FLAG(fv[2]), .RX_CRC_MULTIFRAME_FLAG(fv[1]), .TX_SLIP_FLAG(fv[0]),
      .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .IRQ(irq));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   always @(posedge mclk) cyc <= cyc + 1;

   // ****
   // Shared tasks
   // ****
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      #1 d = rdata;
      check(16'(d), 16'(e));
   endtask

   task automatic send(input logic [15:0] s, input int n);
      for (int i = n - 1; i >= 0; i--) eec_line_model_inst.push(s[2*i+:2]);
   endtask

   // Waits for the timer interrupt, then clears the flag through a status read.
   task automatic bnd();
      for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge mclk);
      check(16'(irq), 16'h1);
      tdet = cyc;
      rchk(8'h20, 8'h10);
      repeat (2) @(posedge mclk);
   endtask

   // ****
   // Scenarios
   // ****
   task automatic t_regs();
      for (int a = 0; a < 6; a++) rchk(8'(a), 8'h00);
      rchk(8'h17, 8'h00);
      rchk(8'h21, 8'h00);
      rchk(8'h30, 8'h00);
      wreg(8'h00, 8'hff);
      rchk(8'h00, 8'h00);
      wreg(8'h17, 8'ha5);
      rchk(8'h17, 8'ha5);
   endtask

   task automatic t_irq();
      for (int i = 0; i < 8; i++) begin
         if (i != 4) begin
            @(posedge mclk);
            fv <= 8'(1 << i);
            wreg(8'h17, 8'(1 << i));
            repeat (2) @(posedge mclk);
            #1 check(16'(irq), 16'h1);
            wreg(8'h17, ~8'(1 << i) & 8'hef);
            repeat (2) @(posedge mclk);
            #1 check(16'(irq), 16'h0);
         end
      end
      @(posedge mclk);
      fv <= 8'h00;
   endtask

   task automatic t_timer();
      wreg(8'h17, 8'h10);
      bnd();
      bnd();
      t0 = tdet;
      bnd();
      check(16'(tdet - t0), 16'(SLOW * RXP));
      wreg(8'h21, 8'h04);
      bnd();
      bnd();
      t0 = tdet;
      bnd();
      check(16'(tdet - t0), 16'(FAST * RXP));
   endtask

   task automatic t_viol();
      wreg(8'h21, 8'h00);
      bnd();
      send(16'(N), 1);
      bnd();
      ls <= 5'h1f;
      // The last violation follows two zeros, yet counts because HDB3 decoding is off.
      send(16'({P, P, N, N, N, Z, Z, N}), 8);
      bnd();
      ls <= 5'h00;
      rchk(8'h00, 8'h00);
      rchk(8'h01, 8'h04);
      wreg(8'h21, 8'h01);
      bnd();
      send(16'({P, Z, Z, P, P}), 5);
      bnd();
      rchk(8'h01, 8'h01);
      wreg(8'h21, 8'h02);
      rchk(8'h01, 8'h01);
      bnd();
      send(16'({N, N, N}), 3);
      bnd();
      send(16'({P, P, P, N, N, N}), 6);
      bnd();
      rchk(8'h01, 8'h02);
   endtask

   task automatic t_frm();
      wreg(8'h21, 8'h00);
      bnd();
      for (int i = 0; i < 1100; i++) begin
         {crc, ebs, ebv} <= 3'h6;
         aln <= (i < 70);
         @(posedge mclk);
      end
      {crc, ebs, aln} <= 3'h0;
      bnd();
      rchk(8'h02, 8'h07);
      rchk(8'h03, 8'hff);
      rchk(8'h04, 8'h1b);
      rchk(8'h05, 8'hff);
      // One pulse of each kind under each loss or search state in turn.
      @(posedge mclk);
      for (int k = 0; k < 7; k++) begin
         {crc, ebs, aln} <= 3'h7;
         ls <= (k < 5) ? 5'(5'h10 >> k) : 5'h00;
         ebv <= (k == 6);
         @(posedge mclk);
      end
      {crc, ebs, aln, ebv} <= 4'h0;
      ls <= 5'h00;
      bnd();
      rchk(8'h02, 8'h00);
      rchk(8'h03, 8'h05);
      rchk(8'h04, 8'h10);
      rchk(8'h05, 8'h04);
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      {rst, wr_s, rd_s, crc, ebs, ebv, aln} = 7'h40;
      {addr, wdata, fv, ls} = 29'h0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_irq();
      t_timer();
      t_viol();
      t_frm();
      conclude();
   end

   initial begin
      repeat (60000) @(posedge mclk);
      fails++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      conclude();
   end
endmodule // tb_eec_top

`default_nettype wire
